// file: logic/ssvs_clkdiv.v
`timescale 1ns/1ps
`include "ssvs_defs.vh"
// Divider producing the separator tick enable
module ssvs_clkdiv (
   // Clock and reset
   input wire i_mclk,
   input wire i_reset,
   // Tick output
   output reg o_tick
);
   localparam [`SSVS_DIV_WIDTH-1:0] DIV_LAST = `SSVS_DIV_LAST;
   reg [`SSVS_DIV_WIDTH-1:0] cnt;
   // Count master cycles, pulse once per separator period
   always @(posedge i_mclk) begin
      if (i_reset) begin
         cnt <= {`SSVS_DIV_WIDTH{1'b0}};
         o_tick <= 1'b0;
      end else if (cnt == DIV_LAST) begin
         cnt <= {`SSVS_DIV_WIDTH{1'b0}};
         o_tick <= 1'b1;
      end else begin
         cnt <= cnt + 1'b1;
         o_tick <= 1'b0;
      end
   end
endmodule // ssvs_clkdiv

// file: logic/ssvs_defs.vh
`ifndef SSVS_DEFS_VH
`define SSVS_DEFS_VH
// Wishbone register byte addresses
`define SSVS_ADDR_SYNC_CTRL 8'h00
`define SSVS_ADDR_SEP_CFG 8'h04
`define SSVS_ADDR_STATUS 8'h08
`define SSVS_ADDR_COUNT 8'h0c
// Sync control fields
`define SSVS_BIT_SEP_SEL 0
`define SSVS_BIT_AVS_OVR 1
`define SSVS_BIT_GREEN_SEL 3
// Separator config fields
`define SSVS_BIT_VSYNC_COAST 5
`define SSVS_THR_MSB 15
`define SSVS_THR_LSB 8
// Status fields
`define SSVS_BIT_ACTIVE_SRC 0
`define SSVS_BIT_VS_DETECT 1
`define SSVS_BIT_SEP_VSYNC 2
// Reset values
`define SSVS_CTRL_RST 8'h00
`define SSVS_CFG_RST 8'h00
`define SSVS_THR_RST 8'h20
// Counter limits
`define SSVS_CNT_ZERO 8'h00
`define SSVS_CNT_MAX 8'hff
`define SSVS_CNT_ONE 8'h01
// Separator tick rate
`define SSVS_CLK_HZ 100000000
`define SSVS_SEP_HZ 5000000
`define SSVS_DIV_WIDTH 5
// Last divider count: twenty master cycles per separator step
`define SSVS_DIV_LAST 5'h13
// Activity timeout for vsync detect, separator ticks
`define SSVS_VS_TIMEOUT 20'h7a120
`endif

// file: logic/ssvs_sync3.v
`timescale 1ns/1ps
// Three-stage synchroniser, change accepted when stages two and three agree
module ssvs_sync3 (
   // Clock and reset
   input wire i_mclk,
   input wire i_reset,
   // Asynchronous input
   input wire i_async,
   // Filtered output
   output reg o_level
);
   reg s1;
   reg s2;
   reg s3;
   // Shift chain and agreement filter
   always @(posedge i_mclk) begin
      if (i_reset) begin
         s1 <= 1'b0;
         s2 <= 1'b0;
         s3 <= 1'b0;
         o_level <= 1'b0;
      end else begin
         s1 <= i_async;
         s2 <= s1;
         s3 <= s2;
         if (s2 == s3) begin
            o_level <= s3;
         end
      end
   end
endmodule // ssvs_sync3

// file: logic/ssvs_top.v
// Local design decisions: the Wishbone slave port and the register addresses.
`timescale 1ns/1ps
`include "ssvs_defs.vh"
// Behaviour
// - Control bits pick hsync or green sync, and coast or vsync.
// - Fourth mux passes vsync input or separator vsync by select bit.
// - Separator is an eight-bit counter stepping at five megahertz.
// - Separator works on polarity-corrected sync, same for either polarity.
// - Searching, count up during pulse, down after, stopping at zero.
// - Vsync declared present when count exceeds programmable threshold.
// - On presence, clear count, then count up while pulse is absent.
// - Vsync ends only when absence count reaches the same threshold.
// - After vsync ends, clear count and restart presence search.
// - Active source flag follows detect unless override forces select bit.
module ssvs_top (
   // Clock and reset
   input wire i_mclk,
   input wire i_reset,
   // Wishbone slave
   input wire i_wb_cyc,
   input wire i_wb_stb,
   input wire i_wb_we,
   input wire [7:0] i_wb_adr,
   input wire [3:0] i_wb_sel,
   input wire [31:0] i_wb_dat,
   output reg [31:0] o_wb_dat,
   output reg o_wb_ack,
   // Sync pins
   input wire i_hsync,
   input wire i_green_channel_sync_input,
   input wire i_coast,
   input wire i_vsync,
   input wire i_csync_invert,
   // Routed sync outputs
   output reg o_hsync_mux,
   output reg o_csync_mux,
   output reg o_coast_mux,
   output reg o_vsync_mux,
   output reg o_active_vertical_source_flag
);
   localparam [1:0] ST_SEARCH = 2'b00;
   localparam [1:0] ST_ACTIVE = 2'b01;

   // Control registers
   reg [7:0] sync_ctrl;
   reg [7:0] sep_cfg;
   reg [7:0] threshold;
   // Separator state
   reg [1:0] state;
   reg [7:0] count;
   reg sep_vsync;
   reg vs_detect;
   reg [19:0] vs_idle;
   reg vs_prev;
   reg [1:0] next_state;
   reg [7:0] next_count;
   reg next_sep_vsync;

   wire tick;
   wire hs_s;
   wire gs_s;
   wire co_s;
   wire vs_s;
   wire inv_s;
   wire green_sel;
   wire sep_sel;
   wire avs_ovr;
   wire csync_raw;
   wire csync_pol;
   wire csync_sep;
   wire avs_next;
   wire wb_req;
   wire wb_wr;
   wire coast_sel;
   wire coast_src;
   wire vsync_src;
   wire cnt_zero;
   wire cnt_max;
   wire thr_over;
   wire thr_reach;
   wire sep_rise;
   reg [31:0] next_rd_dat;

   // Pin synchronisers
   ssvs_sync3 u_sync_hs (
      .i_mclk(i_mclk),
      .i_reset(i_reset),
      .i_async(i_hsync),
      .o_level(hs_s)
   );
   ssvs_sync3 u_sync_gs (
      .i_mclk(i_mclk),
      .i_reset(i_reset),
      .i_async(i_green_channel_sync_input),
      .o_level(gs_s)
   );
   ssvs_sync3 u_sync_co (
      .i_mclk(i_mclk),
      .i_reset(i_reset),
      .i_async(i_coast),
      .o_level(co_s)
   );
   ssvs_sync3 u_sync_vs (
      .i_mclk(i_mclk),
      .i_reset(i_reset),
      .i_async(i_vsync),
      .o_level(vs_s)
   );
   ssvs_sync3 u_sync_inv (
      .i_mclk(i_mclk),
      .i_reset(i_reset),
      .i_async(i_csync_invert),
      .o_level(inv_s)
   );

   // Separator tick enable
   ssvs_clkdiv u_div (
      .i_mclk(i_mclk),
      .i_reset(i_reset),
      .o_tick(tick)
   );

   // Control field decode
   assign green_sel = sync_ctrl[`SSVS_BIT_GREEN_SEL];
   assign sep_sel = sync_ctrl[`SSVS_BIT_SEP_SEL];
   assign avs_ovr = sync_ctrl[`SSVS_BIT_AVS_OVR];

   // Composite sync source and polarity correction
   assign csync_raw = green_sel ? gs_s : hs_s;
   assign csync_pol = csync_raw ^ inv_s;

   // Composite sync sampled on the tick domain before counting
   reg csync_t1;
   reg csync_t2;
   always @(posedge i_mclk) begin
      if (i_reset) begin
         csync_t1 <= 1'b0;
         csync_t2 <= 1'b0;
      end else if (tick) begin
         csync_t1 <= csync_pol;
         csync_t2 <= csync_t1;
      end
   end
   assign csync_sep = csync_t2;

   // Separator compare terms, evaluated on the registered count
   assign cnt_zero = (count == `SSVS_CNT_ZERO);
   assign cnt_max = (count == `SSVS_CNT_MAX);
   assign thr_over = (count > threshold);
   assign thr_reach = (count >= threshold);

   // Separator next-state logic
   always @* begin
      next_state = state;
      next_count = count;
      next_sep_vsync = sep_vsync;
      case (state)
         ST_SEARCH: begin
            if (thr_over) begin
               next_state = ST_ACTIVE;
               next_sep_vsync = 1'b1;
               next_count = `SSVS_CNT_ZERO;
            end else if (csync_sep) begin
               if (!cnt_max) begin
                  next_count = count + `SSVS_CNT_ONE;
               end
            end else if (!cnt_zero) begin
               next_count = count - `SSVS_CNT_ONE;
            end
         end
         ST_ACTIVE: begin
            if (thr_reach) begin
               next_state = ST_SEARCH;
               next_sep_vsync = 1'b0;
               next_count = `SSVS_CNT_ZERO;
            end else if (!csync_sep) begin
               if (!cnt_max) begin
                  next_count = count + `SSVS_CNT_ONE;
               end
            end
         end
         default: begin
            next_state = ST_SEARCH;
            next_count = `SSVS_CNT_ZERO;
            next_sep_vsync = 1'b0;
         end
      endcase
   end

   // Separator registers step only on the five megahertz tick
   always @(posedge i_mclk) begin
      if (i_reset) begin
         state <= ST_SEARCH;
         count <= `SSVS_CNT_ZERO;
         sep_vsync <= 1'b0;
      end else if (tick) begin
         state <= next_state;
         count <= next_count;
         sep_vsync <= next_sep_vsync;
      end
   end

   // Rising edge of the separator output, seen on the tick
   assign sep_rise = sep_vsync & ~vs_prev;

   // Vsync activity detect: edge on separator output within timeout
   always @(posedge i_mclk) begin
      if (i_reset) begin
         vs_prev <= 1'b0;
         vs_idle <= 20'h00000;
         vs_detect <= 1'b0;
      end else if (tick) begin
         vs_prev <= sep_vsync;
         if (sep_rise) begin
            vs_idle <= 20'h00000;
            vs_detect <= 1'b1;
         end else if (vs_idle == `SSVS_VS_TIMEOUT) begin
            vs_detect <= 1'b0;
         end else begin
            vs_idle <= vs_idle + 20'h00001;
         end
      end
   end

   // Active source flag with override
   assign avs_next = avs_ovr ? sep_sel : vs_detect;

   // Mux three and four sources
   assign coast_sel = sep_cfg[`SSVS_BIT_VSYNC_COAST];
   assign coast_src = coast_sel ? vs_s : co_s;
   assign vsync_src = sep_sel ? sep_vsync : vs_s;

   // Registered sync outputs
   always @(posedge i_mclk) begin
      if (i_reset) begin
         o_hsync_mux <= 1'b0;
         o_csync_mux <= 1'b0;
         o_coast_mux <= 1'b0;
         o_vsync_mux <= 1'b0;
         o_active_vertical_source_flag <= 1'b0;
      end else begin
         o_hsync_mux <= csync_raw;
         o_csync_mux <= csync_raw;
         o_coast_mux <= coast_src;
         o_vsync_mux <= vsync_src;
         o_active_vertical_source_flag <= avs_next;
      end
   end

   // Wishbone slave: a request is taken once, ack follows one cycle later
   // and drops after one cycle; writes commit at the edge where the master
   // samples ack, so address, data and select are still held there
   assign wb_req = i_wb_cyc & i_wb_stb & ~o_wb_ack;
   assign wb_wr = i_wb_cyc & i_wb_stb & i_wb_we & o_wb_ack;

   // Read data for the addressed register, zero for unmapped addresses
   always @* begin
      next_rd_dat = 32'h00000000;
      if (i_wb_adr == `SSVS_ADDR_SYNC_CTRL) begin
         next_rd_dat = {24'h000000, sync_ctrl};
      end else if (i_wb_adr == `SSVS_ADDR_SEP_CFG) begin
         next_rd_dat = {16'h0000, threshold, sep_cfg};
      end else if (i_wb_adr == `SSVS_ADDR_STATUS) begin
         next_rd_dat = {29'h0, sep_vsync, vs_detect,
                        o_active_vertical_source_flag};
      end else if (i_wb_adr == `SSVS_ADDR_COUNT) begin
         next_rd_dat = {22'h0, state, count};
      end
   end

   // Ack pulse and read data, captured when the request is taken
   always @(posedge i_mclk) begin
      if (i_reset) begin
         o_wb_ack <= 1'b0;
         o_wb_dat <= 32'h00000000;
      end else begin
         o_wb_ack <= wb_req;
         if (wb_req) begin
            o_wb_dat <= next_rd_dat;
         end
      end
   end

   // Control register writes, byte lanes gated by select
   always @(posedge i_mclk) begin
      if (i_reset) begin
         sync_ctrl <= `SSVS_CTRL_RST;
         sep_cfg <= `SSVS_CFG_RST;
         threshold <= `SSVS_THR_RST;
      end else if (wb_wr) begin
         if (i_wb_adr == `SSVS_ADDR_SYNC_CTRL) begin
            if (i_wb_sel[0]) begin
               sync_ctrl <= i_wb_dat[7:0];
            end
         end else if (i_wb_adr == `SSVS_ADDR_SEP_CFG) begin
            if (i_wb_sel[0]) begin
               sep_cfg <= i_wb_dat[7:0];
            end
            if (i_wb_sel[1]) begin
               threshold <= i_wb_dat[`SSVS_THR_MSB:`SSVS_THR_LSB];
            end
         end
      end
   end
endmodule // ssvs_top

// file: testbench/ssvs_src.sv
`timescale 1ns/1ps
// Graphics source: composite sync on hsync, other pins random
module ssvs_src (
   input wire i_mclk,
   output reg o_hsync,
   output reg o_green,
   output reg o_coast,
   output reg o_vsync
);
   initial begin
      {o_hsync, o_green, o_coast, o_vsync} = 4'h0;
   end
   // Holds the composite line at v for n cycles
   task hold(input v, input integer n);
      begin
         @(posedge i_mclk);
         o_hsync <= v;
         repeat (n - 1) @(posedge i_mclk);
      end
   endtask
   // Random levels on all pins, each held a random time
   task noise(input integer n);
      reg [31:0] r;
      begin
         repeat (n) begin
            @(posedge i_mclk);
            r = $urandom;
            {o_hsync, o_green, o_coast, o_vsync} <= r[3:0];
            repeat (r[7:4]) @(posedge i_mclk);
         end
      end
   endtask
endmodule // ssvs_src

// file: testbench/ssvs_top_properties.sv
`timescale 1ns/1ps
// Watches the routed sync outputs against shadowed control bits
module ssvs_top_properties (
   input wire i_mclk, i_reset, i_wb_cyc, i_wb_stb, i_wb_we,
   input wire [7:0] i_wb_adr,
   input wire [3:0] i_wb_sel,
   input wire [31:0] i_wb_dat, o_wb_dat,
   input wire o_wb_ack, i_hsync, i_green_channel_sync_input, i_coast,
   input wire i_vsync, i_csync_invert, o_hsync_mux, o_csync_mux,
   input wire o_coast_mux, o_vsync_mux, o_active_vertical_source_flag
);
   reg [7:0] ctrl;
   reg [7:0] cfg;
   wire g = i_green_channel_sync_input;
   // Shadow of the control bytes, taken at the acknowledged edge
   always @(posedge i_mclk) begin
      if (i_reset) begin
         ctrl <= 8'h00;
         cfg <= 8'h00;
      end else if (o_wb_ack && i_wb_we && i_wb_sel[0]) begin
         if (i_wb_adr == 8'h00) ctrl <= i_wb_dat[7:0];
         if (i_wb_adr == 8'h04) cfg <= i_wb_dat[7:0];
      end
   end
   default clocking @(posedge i_mclk); endclocking
   default disable iff (i_reset);
   sequence req_s; i_wb_cyc && i_wb_stb && !o_wb_ack; endsequence
   sequence ans_s; o_wb_ack ##1 !o_wb_ack; endsequence
   bus_answer_a: assert property (req_s |=> ans_s)
      else $error("bus answer late or long");
   hsync_route_a: assert property (
      (!ctrl[3] && $stable(i_hsync))[*7]
      |-> o_hsync_mux == i_hsync && o_csync_mux == i_hsync)
      else $error("hsync not routed");
   green_route_a: assert property (
      (ctrl[3] && $stable(g))[*7] |-> o_hsync_mux == g && o_csync_mux == g)
      else $error("green sync not routed");
   coast_route_a: assert property (
      (!cfg[5] && $stable(i_coast))[*7] |-> o_coast_mux == i_coast)
      else $error("coast not routed");
   coast_vsync_a: assert property (
      (cfg[5] && $stable(i_vsync))[*7] |-> o_coast_mux == i_vsync)
      else $error("vsync not on coast mux");
   vsync_pin_a: assert property (
      (!ctrl[0] && $stable(i_vsync))[*7] |-> o_vsync_mux == i_vsync)
      else $error("vsync pin not routed");
   source_override_a: assert property (
      (ctrl[1] && $stable(ctrl[0]))[*3]
      |-> o_active_vertical_source_flag == ctrl[0])
      else $error("override ignored");
   unmapped_zero_a: assert property (
      o_wb_ack && !i_wb_we && i_wb_adr > 8'h0c |-> o_wb_dat == 32'h0)
      else $error("unmapped read not zero");
endmodule // ssvs_top_properties
bind ssvs_top ssvs_top_properties chk (.*);

// file: testbench/ssvs_top_tb.sv
`timescale 1ns/1ps
// Bench for sync routing and the vertical separator
module ssvs_top_tb;
   reg i_mclk = 1'b0;
   reg i_reset = 1'b1;
   reg i_wb_cyc = 1'b0;
   reg i_wb_stb = 1'b0;
   reg i_wb_we = 1'b0;
   reg [7:0] i_wb_adr = 8'h00;
   reg [31:0] i_wb_dat = 32'h0;
   reg i_csync_invert = 1'b0;
   reg [3:0] i_wb_sel = 4'hf;
   reg [31:0] rd;
   reg [31:0] r;
   wire [31:0] o_wb_dat;
   wire o_wb_ack, hs, gs, co, vs, hm, cm, km, vm, af;
   integer err_count = 0;
   integer checks = 0;
   integer cyc_n = 0;
   integer i;
   // Free running clock
   initial begin
      forever #5 i_mclk = ~i_mclk;
   end
   ssvs_src src (.i_mclk(i_mclk), .o_hsync(hs), .o_green(gs),
      .o_coast(co), .o_vsync(vs));
   ssvs_top dut (.i_mclk(i_mclk), .i_reset(i_reset), .i_wb_cyc(i_wb_cyc),
      .i_wb_stb(i_wb_stb), .i_wb_we(i_wb_we), .i_wb_adr(i_wb_adr),
      .i_wb_sel(i_wb_sel), .i_wb_dat(i_wb_dat), .o_wb_dat(o_wb_dat),
      .o_wb_ack(o_wb_ack), .i_hsync(hs), .i_green_channel_sync_input(gs),
      .i_coast(co), .i_vsync(vs), .i_csync_invert(i_csync_invert),
      .o_hsync_mux(hm), .o_csync_mux(cm), .o_coast_mux(km),
      .o_vsync_mux(vm), .o_active_vertical_source_flag(af));
   task print_verdict;
      begin
         $display("checks %0d mismatches %0d", checks, err_count);
         if (err_count == 0 && checks > 0)
            $display("== PASSED ==");
         else
            $display("== FAILED ==");
         $finish;
      end
   endtask
   task chk(input [63:0] nm, input [31:0] exp, input [31:0] got);
      begin
         checks = checks + 1;
         if (got !== exp) begin
            err_count = err_count + 1;
            $display("CHECK FAILED %0s exp %h got %h", nm, exp, got);
         end
      end
   endtask
   // Expected word at the separator config address
   function [31:0] cfg_word(input [7:0] thr, input [7:0] cfg);
      begin
         cfg_word = {16'h0000, thr, cfg};
      end
   endfunction
   // Classic cycle, held until ack is seen high at a rising edge
   task wb(input w, input [7:0] a, input [31:0] d);
      begin
         @(posedge i_mclk);
         {i_wb_cyc, i_wb_stb, i_wb_we} <= {2'b11, w};
         i_wb_adr <= a;
         i_wb_dat <= d;
         @(posedge i_mclk);
         while (o_wb_ack !== 1'b1) @(posedge i_mclk);
         rd = o_wb_dat;
         {i_wb_cyc, i_wb_stb} <= 2'b00;
      end
   endtask
   // Hang guard
   always @(posedge i_mclk) begin
      cyc_n <= cyc_n + 1;
      if (cyc_n == 30000) begin
         err_count = err_count + 1;
         print_verdict;
      end
   end
   initial begin
      i = $urandom(32'h556290af);
      repeat (8) @(posedge i_mclk);
      i_reset <= 1'b0;
      wb(0, 8'h04, 0);
      chk("thr", cfg_word(8'h20, 8'h00), rd);
      wb(0, 8'h10, 0);
      chk("unmap", 0, rd);
      for (i = 0; i < 40; i = i + 1) begin
         r = $urandom & 32'h0b;
         wb(1, 8'h00, r);
         wb(0, 8'h00, 0);
         chk("ctrl", r, rd);
         wb(1, 8'h04, 32'h2000 | ($urandom & 32'h20));
         src.noise(12);
      end
      wb(1, 8'h00, 32'h3);
      repeat (3) @(posedge i_mclk);
      chk("ovr", 1, af);
      $display("routing test done");
      wb(1, 8'h00, 32'h1);
      wb(1, 8'h04, 32'h0400);
      for (i = 0; i < 2; i = i + 1) begin
         i_csync_invert <= i[0];
         src.hold(i[0], 300);
         src.hold(!i[0], 60);
         src.hold(i[0], 300);
         chk("short", 0, vm);
         wb(0, 8'h0c, 0);
         chk("cnt", 0, rd[7:0]);
         src.hold(!i[0], 400);
         chk("on", 1, vm);
         src.hold(i[0], 40);
         chk("hold", 1, vm);
         src.hold(i[0], 200);
         chk("off", 0, vm);
      end
      $display("separator test done");
      wb(1, 8'h00, 32'h0);
      repeat (3) @(posedge i_mclk);
      chk("avs", 1, af);
      wb(0, 8'h08, 0);
      chk("stat", 32'h3, rd);
      i_wb_sel <= 4'h1;
      wb(1, 8'h04, 32'hff20);
      i_wb_sel <= 4'hf;
      wb(0, 8'h04, 0);
      chk("sel", cfg_word(8'h04, 8'h20), rd);
      i_reset <= 1'b1;
      repeat (2) @(posedge i_mclk);
      i_reset <= 1'b0;
      wb(0, 8'h04, 0);
      chk("rst", cfg_word(8'h20, 8'h00), rd);
      chk("rstavs", 0, af);
      $display("register test done");
      wb(1, 8'h04, 32'hff00);
      i_csync_invert <= 1'b0;
      src.hold(1'b1, 6000);
      wb(0, 8'h0c, 0);
      chk("sat", 32'hff, rd[7:0]);
      $display("saturation test done");
      print_verdict;
   end
endmodule // ssvs_top_tb
